// >>> amc_pkg.sv
// shared constants, types and decode helpers of the audio mute controller
package amc_pkg;
  // clock and unmute delay timing
  localparam int CLK_MHZ = 250;
  localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
  // register offsets, shared 8-bit map addressing
  localparam logic [7:0] OFS_AVMUTE = 8'h04;
  localparam logic [7:0] OFS_SPEED = 8'h0F;
  localparam logic [7:0] OFS_MASK0 = 8'h14;
  localparam logic [7:0] OFS_MASK1 = 8'h15;
  localparam logic [7:0] OFS_MASK2 = 8'h16;
  localparam logic [7:0] OFS_UNMUTE = 8'h1A;
  localparam logic [7:0] OFS_IRQ1 = 8'h40;
  localparam logic [7:0] OFS_IRQ2 = 8'h41;
  localparam logic [7:0] OFS_STATUS = 8'h65;
  // field positions
  localparam int BIT_AVMUTE = 6;
  localparam int BIT_DL_MAN = 7;
  localparam int BIT_DL_BYP = 6;
  localparam int BIT_FORCE = 4;
  localparam int BIT_HOLD = 0;
  localparam int WAIT_LSB = 1;
  localparam int BIT_IRQ_EN = 3;
  localparam int SEL_LSB = 0;
  localparam int BIT_STATUS = 6;
  // implemented mask bits and reset values
  localparam logic [7:0] MASK0_USED = 8'h33;
  localparam logic [7:0] MASK1_USED = 8'hEB;
  localparam logic [7:0] MASK2_USED = 8'hFF;
  localparam logic [7:0] MASK0_RST = 8'h02;
  localparam logic [7:0] MASK1_RST = 8'h00;
  localparam logic [7:0] MASK2_RST = 8'h00;
  localparam logic [4:0] SPEED_RST = 5'h1F;
  localparam logic [2:0] WAIT_RST = 3'h0;
  localparam logic [1:0] IRQ2_SEL_MUTE = 2'h1;
  // ramp: 64 steps of 1.5 dB reach silence
  localparam int ATTEN_W = 7;
  localparam logic [ATTEN_W-1:0] ATTEN_MAX = 7'h40;
  localparam int DELAY_DEPTH = 512;
  localparam int SAMPLE_W = 16;

  typedef enum logic [1:0] {AMC_UNMUTED, AMC_MUTED, AMC_WAIT} amc_state_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } amc_sample_t;

  // raw mute conditions, levels from the detectors
  typedef struct packed {
    logic compressed;
    logic format_change;
    logic parity_error;
    logic tmds_clock_irregular;
    logic audio_pll_unlock;
    logic tmds_pll_unlock;
    logic acr_missing;
    logic flatline;
    logic fifo_underflow;
    logic fifo_overflow;
    logic hdmi_mode;
    logic cts_jump;
    logic n_change;
    logic channel_mode_change;
    logic packet_ecc_error;
    logic port_change;
    logic tmds_clock_absent;
  } amc_cond_t;

  // unmute delay code to milliseconds
  function automatic int delay_ms(input logic [2:0] code);
    unique case (code)
      3'h0: delay_ms = 0;
      3'h1: delay_ms = 10;
      3'h2: delay_ms = 25;
      3'h3: delay_ms = 50;
      3'h4: delay_ms = 75;
      3'h5: delay_ms = 100;
      3'h6: delay_ms = 250;
      3'h7: delay_ms = 1000;
    endcase
  endfunction
endpackage

// >>> amc_unmute_timer.sv
// programmable unmute delay counter
`timescale 1ns/1ns
module amc_unmute_timer #(
  parameter int CYCLES_PER_MS = amc_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic cancel,
  input wire logic [2:0] code,
  // status
  output logic busy_r,
  output logic done_r
);
  logic [31:0] cnt_r;

  // load on start, count down, one-cycle done at expiry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (cancel) begin
        busy_r <= 1'b0;
      end else if (start) begin
        cnt_r <= 32'(amc_pkg::delay_ms(code) * CYCLES_PER_MS);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= 32'h1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end

  done_from_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
    done_r |-> $past(busy_r)) else $error("done without a running delay");
endmodule // amc_unmute_timer

// >>> amc_ramp.sv
// volume ramp: attenuation in 1.5 dB steps paced by samples
`timescale 1ns/1ns
module amc_ramp (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pacing and target
  input wire logic tick,
  input wire logic mute,
  input wire logic [4:0] speed,
  // attenuation, 0 is full level
  output logic [amc_pkg::ATTEN_W-1:0] atten_r
);
  logic [4:0] div_r;

  // one step every speed samples; speed 0 behaves as 1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h0;
      atten_r <= '0;
    end else if (tick) begin
      if (div_r + 5'h1 >= speed) begin
        div_r <= 5'h0;
        if (mute && atten_r < amc_pkg::ATTEN_MAX) begin
          atten_r <= atten_r + 7'h1;
        end else if (!mute && atten_r != '0) begin
          atten_r <= atten_r - 7'h1;
        end
      end else begin
        div_r <= div_r + 5'h1;
      end
    end
  end

  ramp_single_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    atten_r != $past(atten_r) |-> $past(tick) &&
      (atten_r == $past(atten_r) + 7'h1 || atten_r == $past(atten_r) - 7'h1))
    else $error("attenuation moved by more than one step");
endmodule // amc_ramp

// >>> amc_mute_ctrl.sv
// audio mute controller: registers, mute state, delay line, ramped output
`timescale 1ns/1ns
module amc_mute_ctrl #(
  parameter int CYCLES_PER_MS = amc_pkg::CYCLES_PER_MS,
  parameter int DELAY_DEPTH = amc_pkg::DELAY_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port: io_map selects the second map
  input wire logic reg_wr,
  input wire logic reg_io_map,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // condition detectors
  input wire amc_pkg::amc_cond_t cond,
  input wire logic gcp_valid,
  input wire logic gcp_avmute,
  input wire logic multichannel,
  // audio stream
  input wire logic sample_valid,
  input wire amc_pkg::amc_sample_t sample_in,
  output logic out_valid_r,
  output amc_pkg::amc_sample_t sample_out_r,
  // mute signal pins
  output logic first_interrupt_pin_r,
  output logic second_interrupt_pin_r
);
  localparam int PTR_W = $clog2(DELAY_DEPTH);

  // register file
  logic [7:0] mask0_r, mask1_r, mask2_r;
  logic [4:0] mute_ramp_speed_r;
  logic delay_line_manual_override_r, delay_line_bypass_r;
  logic force_mute_r, manual_unmute_hold_r;
  logic [2:0] unmute_delay_select_r;
  logic mute_to_irq1_enable_r, mute_to_irq2_enable_r;
  logic [1:0] irq2_source_select_r;
  logic avmute_flag_r;
  // mute state
  amc_pkg::amc_state_t state_r;
  logic hold_d_r;
  logic [23:0] cond_vec, mask_vec;
  logic mute_req, hold_rise, internal_mute;
  logic timer_start, timer_cancel, timer_busy, timer_done;
  // datapath
  amc_pkg::amc_sample_t dl_mem [DELAY_DEPTH];
  logic [PTR_W-1:0] dl_ptr_r;
  amc_pkg::amc_sample_t dl_rd_r, in_d_r;
  logic valid_d_r;
  logic bypass;
  logic [amc_pkg::ATTEN_W-1:0] atten;

  // attenuate one channel: 6 dB per shift, quarter steps by table
  function automatic logic [15:0] apply_gain(input logic [15:0] s,
                                             input logic [6:0] at);
    logic [8:0] frac;
    logic signed [25:0] prod;
    frac = 9'h100;
    unique case (at[1:0])
      2'h0: frac = 9'h100;
      2'h1: frac = 9'h0D7;
      2'h2: frac = 9'h0B5;
      2'h3: frac = 9'h098;
    endcase
    prod = $signed({{10{s[15]}}, s}) * $signed({17'h0, frac});
    prod = prod >>> (8 + 26'(at[6:2]));
    if (at >= amc_pkg::ATTEN_MAX) begin
      apply_gain = 16'h0;
    end else begin
      apply_gain = prod[15:0];
    end
  endfunction

  // register read decode, reserved bits read zero
  function automatic logic [7:0] read_reg(input logic io, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h0;
    if (io) begin
      unique case (a)
        amc_pkg::OFS_IRQ1: d[amc_pkg::BIT_IRQ_EN] = mute_to_irq1_enable_r;
        amc_pkg::OFS_IRQ2: begin
          d[amc_pkg::BIT_IRQ_EN] = mute_to_irq2_enable_r;
          d[amc_pkg::SEL_LSB +: 2] = irq2_source_select_r;
        end
        amc_pkg::OFS_STATUS: d[amc_pkg::BIT_STATUS] = internal_mute;
        default: d = 8'h0;
      endcase
    end else begin
      unique case (a)
        amc_pkg::OFS_AVMUTE: d[amc_pkg::BIT_AVMUTE] = avmute_flag_r;
        amc_pkg::OFS_SPEED: begin
          d[amc_pkg::BIT_DL_MAN] = delay_line_manual_override_r;
          d[amc_pkg::BIT_DL_BYP] = delay_line_bypass_r;
          d[4:0] = mute_ramp_speed_r;
        end
        amc_pkg::OFS_MASK0: d = mask0_r;
        amc_pkg::OFS_MASK1: d = mask1_r;
        amc_pkg::OFS_MASK2: d = mask2_r;
        amc_pkg::OFS_UNMUTE: begin
          d[amc_pkg::BIT_FORCE] = force_mute_r;
          d[amc_pkg::WAIT_LSB +: 3] = unmute_delay_select_r;
          d[amc_pkg::BIT_HOLD] = manual_unmute_hold_r;
        end
        default: d = 8'h0;
      endcase
    end
    read_reg = d;
  endfunction

  // software writes to the control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask0_r <= amc_pkg::MASK0_RST;
      mask1_r <= amc_pkg::MASK1_RST;
      mask2_r <= amc_pkg::MASK2_RST;
      mute_ramp_speed_r <= amc_pkg::SPEED_RST;
      delay_line_manual_override_r <= 1'b0;
      delay_line_bypass_r <= 1'b0;
      force_mute_r <= 1'b0;
      manual_unmute_hold_r <= 1'b0;
      unmute_delay_select_r <= amc_pkg::WAIT_RST;
      mute_to_irq1_enable_r <= 1'b0;
      mute_to_irq2_enable_r <= 1'b0;
      irq2_source_select_r <= 2'h0;
    end else if (reg_wr && reg_io_map) begin
      if (reg_addr == amc_pkg::OFS_IRQ1) begin
        mute_to_irq1_enable_r <= reg_wdata[amc_pkg::BIT_IRQ_EN];
      end
      if (reg_addr == amc_pkg::OFS_IRQ2) begin
        mute_to_irq2_enable_r <= reg_wdata[amc_pkg::BIT_IRQ_EN];
        irq2_source_select_r <= reg_wdata[amc_pkg::SEL_LSB +: 2];
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        amc_pkg::OFS_SPEED: begin
          delay_line_manual_override_r <= reg_wdata[amc_pkg::BIT_DL_MAN];
          delay_line_bypass_r <= reg_wdata[amc_pkg::BIT_DL_BYP];
          mute_ramp_speed_r <= reg_wdata[4:0];
        end
        amc_pkg::OFS_MASK0: mask0_r <= reg_wdata & amc_pkg::MASK0_USED;
        amc_pkg::OFS_MASK1: mask1_r <= reg_wdata & amc_pkg::MASK1_USED;
        amc_pkg::OFS_MASK2: mask2_r <= reg_wdata & amc_pkg::MASK2_USED;
        amc_pkg::OFS_UNMUTE: begin
          force_mute_r <= reg_wdata[amc_pkg::BIT_FORCE];
          unmute_delay_select_r <= reg_wdata[amc_pkg::WAIT_LSB +: 3];
          manual_unmute_hold_r <= reg_wdata[amc_pkg::BIT_HOLD];
        end
        default: ;
      endcase
    end
  end

  // read data lags the address by one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h0;
    end else begin
      reg_rdata_r <= read_reg(reg_io_map, reg_addr);
    end
  end

  // avmute flag follows each received general control packet
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avmute_flag_r <= 1'b0;
    end else if (gcp_valid) begin
      avmute_flag_r <= gcp_avmute;
    end
  end

  // conditions laid out bit for bit like the three mask bytes
  assign cond_vec = {avmute_flag_r, !cond.hdmi_mode, cond.cts_jump, cond.n_change,
                     cond.channel_mode_change, cond.packet_ecc_error,
                     cond.port_change, cond.tmds_clock_absent,
                     cond.audio_pll_unlock, cond.tmds_pll_unlock, cond.acr_missing,
                     1'b0, cond.flatline, 1'b0,
                     cond.fifo_underflow, cond.fifo_overflow,
                     2'b00, cond.compressed, cond.format_change, 2'b00,
                     cond.parity_error, cond.tmds_clock_irregular};
  assign mask_vec = {mask2_r, mask1_r, mask0_r};
  // masked-off conditions count as inactive
  assign mute_req = force_mute_r || |(cond_vec & mask_vec);
  assign hold_rise = manual_unmute_hold_r && !hold_d_r;
  assign internal_mute = (state_r != amc_pkg::AMC_UNMUTED);
  assign timer_start = (state_r == amc_pkg::AMC_MUTED) && !mute_req &&
                       !manual_unmute_hold_r && unmute_delay_select_r != 3'h0;
  // a fresh condition, code zero or a return to manual mode stops the wait
  assign timer_cancel = (state_r == amc_pkg::AMC_WAIT) && (mute_req ||
                        unmute_delay_select_r == 3'h0 || manual_unmute_hold_r);

  amc_unmute_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(timer_start),
    .cancel(timer_cancel),
    .code(unmute_delay_select_r),
    .busy_r(timer_busy),
    .done_r(timer_done)
  );

  // previous hold value for the manual 0-then-1 unmute
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_d_r <= 1'b0;
    end else begin
      hold_d_r <= manual_unmute_hold_r;
    end
  end

  // mute state: any request mutes at once, unmute by mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= amc_pkg::AMC_UNMUTED;
    end else begin
      unique case (state_r)
        amc_pkg::AMC_UNMUTED: begin
          if (mute_req) begin
            state_r <= amc_pkg::AMC_MUTED;
          end
        end
        amc_pkg::AMC_MUTED: begin
          if (!mute_req && manual_unmute_hold_r && hold_rise) begin
            state_r <= amc_pkg::AMC_UNMUTED;
          end else if (!mute_req && !manual_unmute_hold_r) begin
            if (unmute_delay_select_r == 3'h0) begin
              state_r <= amc_pkg::AMC_UNMUTED;
            end else begin
              state_r <= amc_pkg::AMC_WAIT;
            end
          end
        end
        amc_pkg::AMC_WAIT: begin
          if (mute_req || (manual_unmute_hold_r && !hold_rise)) begin
            state_r <= amc_pkg::AMC_MUTED;
          end else if (unmute_delay_select_r == 3'h0 || timer_done || hold_rise) begin
            state_r <= amc_pkg::AMC_UNMUTED;
          end
        end
      endcase
    end
  end

  // mute level onto the interrupt pins, low when not selected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_interrupt_pin_r <= 1'b0;
      second_interrupt_pin_r <= 1'b0;
    end else begin
      first_interrupt_pin_r <= mute_to_irq1_enable_r && internal_mute;
      second_interrupt_pin_r <= mute_to_irq2_enable_r && internal_mute &&
                                irq2_source_select_r == amc_pkg::IRQ2_SEL_MUTE;
    end
  end

  amc_ramp u_ramp (
    .clock(clock),
    .rst_n(rst_n),
    .tick(sample_valid),
    .mute(internal_mute),
    .speed(mute_ramp_speed_r),
    .atten_r(atten)
  );

  // delay line memory: read the oldest sample before overwriting it
  always_ff @(posedge clock) begin
    if (sample_valid) begin
      dl_mem[dl_ptr_r] <= sample_in;
      dl_rd_r <= dl_mem[dl_ptr_r];
    end
  end

  // write pointer and input pipeline stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dl_ptr_r <= '0;
      in_d_r <= '0;
      valid_d_r <= 1'b0;
    end else begin
      valid_d_r <= sample_valid;
      if (sample_valid) begin
        dl_ptr_r <= (dl_ptr_r == PTR_W'(DELAY_DEPTH - 1)) ? '0 : dl_ptr_r + 1'b1;
        in_d_r <= sample_in;
      end
    end
  end

  // multichannel skips the delay line unless software overrides
  assign bypass = delay_line_manual_override_r ? delay_line_bypass_r : multichannel;

  // output stage; compressed streams go straight to zero while muted, ramped back up on unmute
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      sample_out_r <= '0;
    end else begin
      out_valid_r <= valid_d_r;
      if (valid_d_r) begin
        if (cond.compressed && internal_mute) begin
          sample_out_r <= '0;
        end else if (bypass) begin
          sample_out_r.left <= apply_gain(in_d_r.left, atten);
          sample_out_r.right <= apply_gain(in_d_r.right, atten);
        end else begin
          sample_out_r.left <= apply_gain(dl_rd_r.left, atten);
          sample_out_r.right <= apply_gain(dl_rd_r.right, atten);
        end
      end
    end
  end

  request_mutes_a: assert property (@(posedge clock) disable iff (!rst_n)
    mute_req |=> state_r != amc_pkg::AMC_UNMUTED) else $error("request did not mute");
  hold_blocks_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == amc_pkg::AMC_MUTED && manual_unmute_hold_r && !hold_rise
    |=> state_r == amc_pkg::AMC_MUTED) else $error("unmuted while held");
  no_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == amc_pkg::AMC_MUTED && !mute_req && !manual_unmute_hold_r &&
    unmute_delay_select_r == 3'h0 |=> !internal_mute) else $error("code zero did not unmute");
  delay_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == amc_pkg::AMC_MUTED && !mute_req && !manual_unmute_hold_r &&
    unmute_delay_select_r != 3'h0 |=> state_r == amc_pkg::AMC_WAIT && timer_busy)
    else $error("delay wait not started");
  stays_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == amc_pkg::AMC_UNMUTED && !mute_req |=> !internal_mute)
    else $error("muted without a request");
  irq1_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 first_interrupt_pin_r == $past(mute_to_irq1_enable_r && internal_mute))
    else $error("first pin wrong");
  irq2_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    second_interrupt_pin_r |-> $past(irq2_source_select_r) == amc_pkg::IRQ2_SEL_MUTE &&
    $past(mute_to_irq2_enable_r) && $past(internal_mute)) else $error("second pin wrong");
  status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_io_map && reg_addr == amc_pkg::OFS_STATUS
    |=> reg_rdata_r[amc_pkg::BIT_STATUS] == $past(internal_mute)) else $error("status wrong");
  avmute_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    gcp_valid |=> avmute_flag_r == $past(gcp_avmute)) else $error("avmute flag not taken");
  zero_compressed_a: assert property (@(posedge clock) disable iff (!rst_n)
    valid_d_r && cond.compressed && internal_mute |=> sample_out_r == '0)
    else $error("compressed audio not zeroed");
endmodule // amc_mute_ctrl

// >>> amc_audio_sink.sv
// downstream audio processor model: takes the sample stream and the mute pin
`timescale 1ns/1ns
module amc_audio_sink (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // audio and mute from the controller
  input wire logic valid,
  input wire amc_pkg::amc_sample_t sample,
  input wire logic mute_pin,
  // what the processor saw
  output amc_pkg::amc_sample_t last_r,
  output logic [15:0] count_r,
  output logic muted_r
);
  // capture each delivered sample; the pin is only a level, so it is sampled too
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= '0;
      count_r <= 16'h0000;
      muted_r <= 1'b0;
    end else begin
      muted_r <= mute_pin;
      if (valid) begin
        last_r <= sample;
        count_r <= count_r + 16'h0001;
      end
    end
  end
endmodule // amc_audio_sink

// >>> testbench.sv
// self-checking bench of the audio mute controller
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic clock, rst_n, reg_wr, reg_io_map, gcp_valid, gcp_avmute, multichannel, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d;
  amc_pkg::amc_cond_t cond;
  amc_pkg::amc_sample_t sample_in, sample_out_r, last_r;
  logic out_valid_r, pin1, pin2, muted_r;
  logic [15:0] count_r;
  int bad_count, tests_run;
  localparam logic [16:0] IDLE = 17'h00040; // hdmi_mode high is the quiet level
  amc_mute_ctrl #(.CYCLES_PER_MS(10), .DELAY_DEPTH(512)) u_dut (.clock(clock), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_io_map(reg_io_map), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .cond(cond), .gcp_valid(gcp_valid), .gcp_avmute(gcp_avmute),
    .multichannel(multichannel), .sample_valid(sample_valid), .sample_in(sample_in),
    .out_valid_r(out_valid_r), .sample_out_r(sample_out_r),
    .first_interrupt_pin_r(pin1), .second_interrupt_pin_r(pin2));
  amc_audio_sink u_sink (.clock(clock), .rst_n(rst_n), .valid(out_valid_r),
    .sample(sample_out_r), .mute_pin(pin1), .last_r(last_r), .count_r(count_r),
    .muted_r(muted_r));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // register write, one strobe cycle
  task automatic wr(input logic m, input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_io_map = m; reg_addr = a; reg_wdata = v; reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // register read; data is registered one edge after the address
  task automatic rd(input logic m, input logic [7:0] a);
    @(negedge clock);
    reg_io_map = m; reg_addr = a;
    @(negedge clock);
    d = reg_rdata_r;
  endtask
  // let state and pins settle, then read internal mute status
  task automatic st(input int n);
    repeat (n) @(negedge clock);
    rd(1'b1, 8'h65);
  endtask
  task automatic t_reset();
    rd(1'b0, 8'h0F); `CHK(d, 8'h1F)
    rd(1'b0, 8'h14); `CHK(d, 8'h02)
    rd(1'b0, 8'h1A); `CHK(d, 8'h00)
    rd(1'b0, 8'h04); `CHK(d, 8'h00)
    rd(1'b1, 8'h65); `CHK(d[6], 1'b0)
    rd(1'b0, 8'h33); `CHK(d, 8'h00)
    wr(1'b0, 8'h0F, 8'h01); rd(1'b0, 8'h0F); `CHK(d[4:0], 5'h01)
    $display("test reset done");
  endtask
  // bypassed path at 0 dB: output one edge after the pipeline stage, untouched
  task automatic t_stream();
    multichannel = 1'b1;
    @(negedge clock);
    sample_in = 32'h1234ABCD; sample_valid = 1'b1;
    @(negedge clock); sample_valid = 1'b0; `CHK(out_valid_r, 1'b0)
    @(negedge clock); `CHK(out_valid_r, 1'b1)
    @(negedge clock); `CHK(last_r, 32'h1234ABCD)
    // stereo goes through the delay line: a word returns 512 samples later
    multichannel = 1'b0;
    for (int k = 0; k <= 512; k++) begin
      @(negedge clock); sample_in = 32'h5A5A0000 | 32'(k); sample_valid = 1'b1;
      @(negedge clock); sample_valid = 1'b0;
    end
    repeat (2) @(negedge clock); `CHK(last_r, 32'h5A5A0000)
    // manual override bypasses the line even for stereo
    wr(1'b0, 8'h0F, 8'hC1);
    @(negedge clock); sample_in = 32'h0F0F1234; sample_valid = 1'b1;
    @(negedge clock); sample_valid = 1'b0;
    repeat (2) @(negedge clock); `CHK(last_r, 32'h0F0F1234)
    wr(1'b0, 8'h0F, 8'h01); multichannel = 1'b1;
    $display("test stream done");
  endtask
  task automatic t_masks();
    wr(1'b1, 8'h40, 8'h08); wr(1'b1, 8'h41, 8'h09);
    for (int j = 0; j < 2; j++) begin
      wr(1'b0, 8'h14, j ? 8'h33 : 8'h00);
      wr(1'b0, 8'h15, j ? 8'hEB : 8'h00);
      wr(1'b0, 8'h16, j ? 8'hFF : 8'h00);
      for (int i = 0; i < 17; i++) begin
        cond = IDLE ^ (17'h00001 << i);
        st(3); `CHK(d[6], 1'(j))
        `CHK({pin1, pin2}, {2{1'(j)}})
        cond = IDLE;
        st(3); `CHK(d[6], 1'b0)
      end
    end
    @(negedge clock); gcp_avmute = 1'b1; gcp_valid = 1'b1;
    @(negedge clock); gcp_valid = 1'b0;
    rd(1'b0, 8'h04); `CHK(d, 8'h40)
    st(3); `CHK(d[6], 1'b1)
    @(negedge clock); gcp_avmute = 1'b0; gcp_valid = 1'b1;
    @(negedge clock); gcp_valid = 1'b0;
    st(3); `CHK(d[6], 1'b0)
    $display("test masks done");
  endtask
  task automatic t_force();
    wr(1'b0, 8'h16, 8'h00); wr(1'b1, 8'h41, 8'h0A);
    wr(1'b0, 8'h1A, 8'h10); st(3); `CHK(d[6], 1'b1)
    `CHK({pin1, pin2, muted_r}, 3'h5)
    wr(1'b1, 8'h40, 8'h00); st(1); `CHK(pin1, 1'b0)
    wr(1'b0, 8'h1A, 8'h11); wr(1'b0, 8'h1A, 8'h01);
    st(20); `CHK(d[6], 1'b1)
    // long delay code: only the 0-then-1 toggle can unmute this quickly
    wr(1'b0, 8'h1A, 8'h0E); wr(1'b0, 8'h1A, 8'h0F);
    st(3); `CHK(d[6], 1'b0)
    $display("test force and hold done");
  endtask
  // delayed unmute: 10 cycles per ms here
  task automatic t_delay();
    int ms[2] = '{10, 25};
    for (int c = 1; c < 3; c++) begin
      wr(1'b0, 8'h1A, 8'h10 | 8'(c << 1)); st(3);
      wr(1'b0, 8'h1A, 8'(c << 1));
      st(ms[c-1] * 10 - 20); `CHK(d[6], 1'b1)
      st(30); `CHK(d[6], 1'b0)
    end
    wr(1'b0, 8'h1A, 8'h1E); st(3); wr(1'b0, 8'h1A, 8'h0E);
    st(20); wr(1'b0, 8'h1A, 8'h00);
    st(3); `CHK(d[6], 1'b0)
    $display("test delay done");
  endtask
  // compressed audio mutes to zero words
  task automatic t_zero();
    wr(1'b0, 8'h14, 8'h20); cond = IDLE | 17'h10000; st(3);
    @(negedge clock); sample_in = 32'h7FFF7FFF; sample_valid = 1'b1;
    @(negedge clock); sample_valid = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(last_r, 32'h00000000)
    `CHK(count_r, 16'h0204)
    cond = IDLE;
    $display("test zero done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    summarize();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_io_map = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    cond = IDLE; gcp_valid = 1'b0; gcp_avmute = 1'b0; multichannel = 1'b0;
    sample_valid = 1'b0; sample_in = '0; bad_count = 0; tests_run = 0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    t_reset(); t_stream(); t_masks(); t_force(); t_delay(); t_zero();
    summarize();
  end
endmodule // testbench
